// file: hw/sar_adc_control.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
// How it works
// - Successive approximation, one bit per decision step, eight-bit unsigned result.
// - Speed bit clear gives 62 clocks per conversion, set gives 31.
// - Three channel bits pick one of eight analog inputs in binary.
// - Mode register bits six to three read one and ignore writes.
// - Mode register resets to 0x78, slow speed, channel zero.
// - Writing one to the start flag begins a conversion; flag reads one meanwhile.
// - Start flag reads one while converting, zero otherwise, resets to zero.
// - Writing zero to the start flag aborts a running conversion.
// - The period runs from flag set until the device clears it.
// - At completion the result loads and the start flag clears together.
// - Result holds until the next conversion completes; it keeps the old value during one.
// - Result register is readable any time; writes are ignored.
// - Reset leaves the result register untouched.
// - Each completion sets the request flag; interrupt only when enabled.
// - Start register bits six to zero read one; register resets to 0x7F.
// - Each pin select bit makes its pin analog; resets to 0x00.
module sar_adc_control
   import sar_adc_pkg::*;
#(
   parameter int CH_COUNT = 8
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic [15:0]         bus_addr,
   input  wire logic [7:0]          bus_wdata,
   input  wire logic                bus_wr,
   input  wire logic                bus_rd,
   output logic      [7:0]          bus_rdata,
   input  wire logic                cmp_high,
   output logic      [7:0]          dac_code,
   output logic      [2:0]          channel_sel,
   output logic                     sample_hold,
   output logic      [CH_COUNT-1:0] analog_pin_n_select,
   output logic                     conv_done_strobe,
   output logic                     conv_irq
);

   bus_req_t    req;
   conv_state_t state_reg;
   logic        speed_select_reg;
   logic [2:0]  channel_reg;
   logic        start_flag_reg;
   logic [7:0]  result_reg;
   logic [7:0]  trial_reg;
   logic [2:0]  bit_idx_reg;
   logic [5:0]  cycle_reg;
   logic [5:0]  period;
   logic [5:0]  step_len;
   logic        conv_done_request_reg;
   logic        conv_done_irq_enable_reg;
   logic [CH_COUNT-1:0] pin_sel_reg;
   logic        wr_mode;
   logic        wr_start;
   logic        wr_irq;
   logic        start_cmd;
   logic        stop_cmd;
   logic        finish;
   logic        step_end;
   logic [5:0]  sample_len;
   logic [7:0]  read_value;

   // Bundle the bus inputs so the decode below reads as one request.
   assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   // Write decode.
   assign wr_mode   = req.wr && (req.addr == CONV_MODE_ADDR);
   assign wr_start  = req.wr && (req.addr == CONV_START_ADDR);
   assign wr_irq    = req.wr && (req.addr == IRQ_CTRL_ADDR);
   assign start_cmd = wr_start && req.wdata[START_BIT];
   assign stop_cmd  = wr_start && !req.wdata[START_BIT];

   // Period selection; the step length splits the period into a sample slot plus eight decisions.
   assign period   = speed_select_reg ? FAST_PERIOD : SLOW_PERIOD;
   assign step_len = period >> 3;
   // The sample slot takes whatever the eight steps and the completion cycle leave over.
   assign sample_len = period - {step_len[2:0], 3'h0} - 6'd1;
   assign step_end = (cycle_reg == 6'd1);
   assign finish   = (state_reg == ST_DONE);

   // Mode register; only speed and channel bits are stored, reserved bits are constants.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_select_reg <= CONV_MODE_RESET[SPEED_BIT];
         channel_reg      <= CONV_MODE_RESET[2:0];
      end else if (wr_mode) begin
         speed_select_reg <= req.wdata[SPEED_BIT];
         channel_reg      <= req.wdata[2:0];
      end
   end

   // Pin function select, write-only from software.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sel_reg <= PIN_ANALOG_RESET[CH_COUNT-1:0];
      end else if (req.wr && (req.addr == PIN_ANALOG_ADDR)) begin
         pin_sel_reg <= req.wdata[CH_COUNT-1:0];
      end
   end

   // Start flag: set by software, cleared by abort or by completion.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_flag_reg <= 1'b0;
      end else if (start_cmd) begin
         start_flag_reg <= 1'b1;
      end else if (stop_cmd || finish) begin
         start_flag_reg <= 1'b0;
      end
   end

   // Timing budget: the flag is high for the sample slot, eight decision steps of step_len
   // cycles each and one completion cycle, which together make exactly the selected period.
   // With 62 clocks a step is 7 cycles and the slot 5; with 31 a step is 3 and the slot 6.
   // The comparator is read on the last cycle of each step, so it has a full step to settle.
   // A start written during a conversion restarts it from the top.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ST_IDLE;
         cycle_reg   <= 6'd0;
         bit_idx_reg <= 3'd0;
         trial_reg   <= 8'h00;
      end else if (start_cmd) begin
         state_reg   <= ST_SAMPLE;
         cycle_reg   <= sample_len;
         bit_idx_reg <= 3'd7;
         trial_reg   <= 8'h80;
      end else if (stop_cmd) begin
         state_reg   <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               cycle_reg <= 6'd0;
            end
            ST_SAMPLE: begin
               if (step_end) begin
                  state_reg <= ST_DECIDE;
                  cycle_reg <= step_len;
               end else begin
                  cycle_reg <= cycle_reg - 6'd1;
               end
            end
            ST_DECIDE: begin
               if (step_end) begin
                  // Keep the trial bit if the input is at or above the trial level.
                  trial_reg[bit_idx_reg] <= cmp_high;
                  if (bit_idx_reg == 3'd0) begin
                     state_reg <= ST_DONE;
                  end else begin
                     trial_reg[bit_idx_reg - 3'd1] <= 1'b1;
                     bit_idx_reg <= bit_idx_reg - 3'd1;
                     cycle_reg   <= step_len;
                  end
               end else begin
                  cycle_reg <= cycle_reg - 6'd1;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Result is loaded only at completion and has no reset term, so reset leaves it alone.
   always_ff @(posedge sys_clk) begin
      if (finish && !start_cmd && !stop_cmd) begin
         result_reg <= trial_reg;
      end
   end

   // Completion strobe, one cycle, coincides with the start flag clearing.
   assign conv_done_strobe = finish && !start_cmd && !stop_cmd;

   // Request flag; a completion in the clearing cycle wins over the clear, so no event is lost.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_done_request_reg <= 1'b0;
      end else if (conv_done_strobe) begin
         conv_done_request_reg <= 1'b1;
      end else if (wr_irq && !req.wdata[REQ_BIT]) begin
         conv_done_request_reg <= 1'b0;
      end
   end

   // Interrupt enable; writing one to the request bit has no effect, so software clears with a zero.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_done_irq_enable_reg <= 1'b0;
      end else if (wr_irq) begin
         conv_done_irq_enable_reg <= req.wdata[IRQ_EN_BIT];
      end
   end

   assign conv_irq = conv_done_request_reg && conv_done_irq_enable_reg;

   // Analog front end controls.
   assign dac_code            = trial_reg;
   assign channel_sel         = channel_reg;
   assign sample_hold         = (state_reg == ST_SAMPLE);
   assign analog_pin_n_select = pin_sel_reg;

   // Read multiplexer; write-only and unmapped addresses read zero.
   always_comb begin
      read_value = 8'h00;
      unique case (req.addr)
         CONV_MODE_ADDR:   read_value = CONV_MODE_ONES | {speed_select_reg, 4'h0, channel_reg};
         CONV_RESULT_ADDR: read_value = result_reg;
         CONV_START_ADDR:  read_value = CONV_START_ONES | {start_flag_reg, 7'h00};
         IRQ_CTRL_ADDR:    read_value = {6'h00, conv_done_irq_enable_reg, conv_done_request_reg};
         default:          read_value = 8'h00;
      endcase
   end

   // Read data one cycle after the strobe, then back to zero so a stale value never lingers.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata <= 8'h00;
      end else if (req.rd) begin
         bus_rdata <= read_value;
      end else begin
         bus_rdata <= 8'h00;
      end
   end

   // Assertions.
   logic [6:0] run_len;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_len <= 7'd0;
      end else if (start_cmd) begin
         run_len <= 7'd1;
      end else if (start_flag_reg) begin
         run_len <= run_len + 7'd1;
      end
   end

   period_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |-> run_len == {1'b0, period})
      else $error("Conversion length differs from selected period.");

   flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |=> !start_flag_reg)
      else $error("Start flag did not clear at completion.");

   result_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |=> result_reg == $past(trial_reg))
      else $error("Result not loaded at completion.");

   abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stop_cmd |=> !start_flag_reg && state_reg == ST_IDLE)
      else $error("Abort did not stop conversion.");

   start_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_cmd |=> start_flag_reg && state_reg == ST_SAMPLE)
      else $error("Start did not begin conversion.");

   req_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |=> conv_done_request_reg)
      else $error("Request flag not set on completion.");

   mode_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && req.addr == CONV_MODE_ADDR |=> bus_rdata[6:3] == 4'hF)
      else $error("Mode reserved bits not read as one.");

   start_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && req.addr == CONV_START_ADDR |=> bus_rdata[6:0] == 7'h7F && bus_rdata[7] == $past(start_flag_reg))
      else $error("Start register read value wrong.");

   result_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !start_flag_reg && !conv_done_strobe |=> $stable(result_reg))
      else $error("Result changed while idle.");

   // Sequencer and flag stay in step: the flag is high exactly while the state machine is busy.
   busy_match_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE) == !start_flag_reg)
      else $error("Start flag and sequencer disagree.");

   start_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_flag_reg && !stop_cmd && !conv_done_strobe |=> start_flag_reg)
      else $error("Start flag dropped during a conversion.");

   run_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_flag_reg |-> run_len <= {1'b0, period})
      else $error("Conversion ran past the selected period.");

   sample_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_cmd |=> sample_hold)
      else $error("Sampling did not open the conversion.");

   idle_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !start_flag_reg |-> !sample_hold)
      else $error("Sampling outside a conversion.");

   strobe_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |=> !conv_done_strobe)
      else $error("Completion strobe longer than one cycle.");

   strobe_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |-> start_flag_reg)
      else $error("Completion strobe outside a conversion.");

   done_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe |=> state_reg == ST_IDLE)
      else $error("Sequencer not idle after completion.");

   // Decision path: midscale while sampling, and the top bit follows the comparator.
   sample_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sample_hold |-> dac_code == 8'h80)
      else $error("Trial code not at midscale while sampling.");

   msb_decide_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == ST_DECIDE && step_end && bit_idx_reg == 3'd7 && !start_cmd && !stop_cmd
      |=> dac_code[7] == $past(cmp_high) && dac_code[6])
      else $error("Top decision not taken from the comparator.");

   // Register side: stored fields change only on their own writes.
   speed_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_mode |=> speed_select_reg == $past(req.wdata[SPEED_BIT]))
      else $error("Speed bit not written.");

   channel_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_mode |=> channel_sel == $past(req.wdata[2:0]))
      else $error("Channel select not written.");

   mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !wr_mode |=> $stable(speed_select_reg) && $stable(channel_reg))
      else $error("Mode changed without a write.");

   pin_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.wr && req.addr == PIN_ANALOG_ADDR |=> analog_pin_n_select == $past(req.wdata[CH_COUNT-1:0]))
      else $error("Pin select not written.");

   pin_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(req.wr && req.addr == PIN_ANALOG_ADDR) |=> $stable(analog_pin_n_select))
      else $error("Pin select changed without a write.");

   pin_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && req.addr == PIN_ANALOG_ADDR |=> bus_rdata == 8'h00)
      else $error("Write-only pin select returned data.");

   // The result has no reset value, so these two only mean something once a conversion has run.
   result_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && req.addr == CONV_RESULT_ADDR |=> bus_rdata == $past(result_reg))
      else $error("Result read value wrong.");

   result_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.wr && req.addr == CONV_RESULT_ADDR && !conv_done_strobe |=> $stable(result_reg))
      else $error("Result changed by a write.");

   req_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_request_reg && !(wr_irq && !req.wdata[REQ_BIT]) |=> conv_done_request_reg)
      else $error("Request flag dropped without a clear.");

   req_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_irq && !req.wdata[REQ_BIT] && !conv_done_strobe |=> !conv_done_request_reg)
      else $error("Request flag not cleared.");

   irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_done_strobe && conv_done_irq_enable_reg |=> conv_irq)
      else $error("Enabled completion raised no interrupt.");

   done_cover_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) conv_done_strobe);
   fast_cover_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) conv_done_strobe && speed_select_reg);
   abort_cover_c: cover property (@(posedge sys_clk) disable iff (!rst_n) stop_cmd && start_flag_reg);
   irq_cover_c:   cover property (@(posedge sys_clk) disable iff (!rst_n) conv_irq);
   restart_cover_c: cover property (@(posedge sys_clk) disable iff (!rst_n) start_cmd && start_flag_reg);

endmodule : sar_adc_control

// file: hw/sar_adc_pkg.sv
package sar_adc_pkg;

   // Register addresses on the 16-bit processor address space.
   localparam logic [15:0] CONV_MODE_ADDR   = 16'hFFBC;
   localparam logic [15:0] CONV_RESULT_ADDR = 16'hFFBD;
   localparam logic [15:0] CONV_START_ADDR  = 16'hFFBE;
   localparam logic [15:0] PIN_ANALOG_ADDR  = 16'hFFEF;
   // The interrupt flag and its enable live in a register of this block's own.
   localparam logic [15:0] IRQ_CTRL_ADDR    = 16'hFFC0;

   // Field positions.
   localparam int SPEED_BIT      = 7;
   localparam int START_BIT      = 7;
   localparam int REQ_BIT        = 0;
   localparam int IRQ_EN_BIT     = 1;

   // Reset and fixed values.
   localparam logic [7:0] CONV_MODE_RESET  = 8'h78;
   localparam logic [7:0] CONV_MODE_ONES   = 8'h78;
   localparam logic [7:0] CONV_START_ONES  = 8'h7F;
   localparam logic [7:0] PIN_ANALOG_RESET = 8'h00;

   // Conversion periods in system clock periods.
   localparam logic [5:0] SLOW_PERIOD = 6'd62;
   localparam logic [5:0] FAST_PERIOD = 6'd31;
   localparam int         RESULT_BITS = 8;

   // Register bus request carried as one bundle.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DECIDE, ST_DONE} conv_state_t;

endpackage : sar_adc_pkg

// file: test/sar_front_model.sv
`timescale 1ns/10ps
// Comparator front end: it follows the selected input while sampling, then holds it and compares it with the trial code.
module sar_front_model (
   input  wire logic [2:0]  channel_sel,
   input  wire logic        sample_hold,
   input  wire logic [7:0]  dac_code,
   input  wire logic [63:0] level_bus,
   output logic             cmp_high
);
   logic [7:0] held;
   // The held level follows the pin only while sampling, so a late pin change cannot leak into the decisions.
   always @(*) begin
      if (sample_hold) begin
         held = level_bus[channel_sel*8 +: 8];
      end
   end
   // High means the held input is at or above the trial code.
   assign cmp_high = (held >= dac_code);
endmodule : sar_front_model

// file: test/tb_sar_adc_control.sv
`timescale 1ns/10ps
module tb_sar_adc_control;
   import sar_adc_pkg::*;
   logic        sys_clk, rst_n, bus_wr, bus_rd, cmp_high, sample_hold, conv_done_strobe, conv_irq, rd_pend;
   logic [15:0] bus_addr;
   logic [7:0]  bus_wdata, bus_rdata, dac_code, analog_pin_n_select, lvl;
   logic [2:0]  channel_sel, ch;
   logic [63:0] level_bus;
   logic [31:0] seed;
   logic [7:0]  exp_q[$];
   int          mismatches, cmp_count, n, k;

   sar_adc_control sar_adc_control_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_high(cmp_high),
      .dac_code(dac_code), .channel_sel(channel_sel), .sample_hold(sample_hold),
      .analog_pin_n_select(analog_pin_n_select), .conv_done_strobe(conv_done_strobe), .conv_irq(conv_irq));
   sar_front_model sar_front_model_i (.channel_sel(channel_sel), .sample_hold(sample_hold),
      .dac_code(dac_code), .level_bus(level_bus), .cmp_high(cmp_high));

   // Free-running system clock.
   always #5 sys_clk = ~sys_clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge sys_clk);
      bus_wr    <= 1'b0;
   endtask : bus_write

   task automatic bus_read(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      exp_q.push_back(exp);
      @(posedge sys_clk);
      bus_rd   <= 1'b0;
   endtask : bus_read

   // Read data stand only in the cycle after the strobe, so they are compared mid-cycle, away from both edges.
   always @(negedge sys_clk) begin
      if (rd_pend) check(bus_rdata, exp_q.pop_front());
      rd_pend = bus_rd;
   end

   // One conversion: the strobe must land on the last cycle of the period, then flag, result and request follow.
   task automatic conv_run(input logic speed, input logic en, input int i);
      ch = 3'($random(seed));
      level_bus = {$random(seed), $random(seed)};
      if (i < 2) level_bus[ch*8 +: 8] = i[0] ? 8'h00 : 8'hFF;
      lvl = level_bus[ch*8 +: 8];
      bus_write(CONV_MODE_ADDR, {speed, 4'hF, ch});
      bus_write(PIN_ANALOG_ADDR, 8'h01 << ch);
      bus_write(IRQ_CTRL_ADDR, {6'h00, en, 1'b0});
      @(negedge sys_clk);
      check({5'h00, channel_sel}, {5'h00, ch});
      check(analog_pin_n_select, 8'h01 << ch);
      bus_write(CONV_START_ADDR, 8'h80);
      n = 1;
      #1;
      check({7'h00, sample_hold}, 8'h01);
      check(dac_code, 8'h80);
      while (conv_done_strobe !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 100) begin
         mismatches++;
         print_verdict();
      end
      check(8'(n), speed ? 8'h1F : 8'h3E);
      bus_read(CONV_START_ADDR, 8'h7F);
      bus_read(CONV_RESULT_ADDR, lvl);
      bus_write(CONV_RESULT_ADDR, ~lvl);
      bus_read(CONV_RESULT_ADDR, lvl);
      @(negedge sys_clk);
      check({7'h00, conv_irq}, {7'h00, en});
      bus_write(IRQ_CTRL_ADDR, 8'h03);
      @(negedge sys_clk);
      check({7'h00, conv_irq}, 8'h01);
      bus_write(IRQ_CTRL_ADDR, 8'h00);
      @(negedge sys_clk);
      check({7'h00, conv_irq}, 8'h00);
   endtask : conv_run

   // Main sequence: reset values, reserved bits, conversions at both speeds, then an abort.
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      rd_pend = 1'b0;
      level_bus = 64'h0;
      seed = 32'hF71400C2;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus_read(CONV_MODE_ADDR, 8'h78);
      bus_read(CONV_START_ADDR, 8'h7F);
      bus_read(PIN_ANALOG_ADDR, 8'h00);
      bus_read(16'h1234, 8'h00);
      bus_write(CONV_MODE_ADDR, 8'h07);
      bus_read(CONV_MODE_ADDR, 8'h7F);
      bus_write(CONV_MODE_ADDR, 8'h80);
      bus_read(CONV_MODE_ADDR, 8'hF8);
      bus_write(CONV_START_ADDR, 8'h00);
      bus_read(CONV_START_ADDR, 8'h7F);
      for (int i = 0; i < 4; i++) conv_run(i[0], i[1], i);
      // A reset while idle restores the registers but must leave the last result in place.
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus_read(CONV_RESULT_ADDR, lvl);
      bus_read(CONV_MODE_ADDR, 8'h78);
      // Abort: no strobe may follow within a full slow period.
      bus_write(CONV_MODE_ADDR, 8'h78);
      bus_write(CONV_START_ADDR, 8'h80);
      bus_read(CONV_START_ADDR, 8'hFF);
      bus_write(CONV_START_ADDR, 8'h00);
      bus_read(CONV_START_ADDR, 8'h7F);
      k = 0;
      repeat (80) begin
         @(negedge sys_clk);
         if (conv_done_strobe === 1'b1) k++;
      end
      check(8'(k), 8'h00);
      print_verdict();
   end
endmodule : tb_sar_adc_control
